/* File: rtl/dbt_pkg.sv */
package dbt_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] DBT_ADDR_CTRL = 8'h00;
    localparam logic [7:0] DBT_ADDR_PRESET = 8'h04;
    localparam logic [7:0] DBT_ADDR_RELOAD0 = 8'h08;
    localparam logic [7:0] DBT_ADDR_RELOAD1 = 8'h0c;
    localparam logic [7:0] DBT_ADDR_CNT0_LO = 8'h10;
    localparam logic [7:0] DBT_ADDR_CNT0_HI = 8'h14;
    localparam logic [7:0] DBT_ADDR_CNT1_LO = 8'h18;
    localparam logic [7:0] DBT_ADDR_CNT1_HI = 8'h1c;
    localparam logic [7:0] DBT_ADDR_IRQ_FLAG = 8'h20;

    // ==========================================================
    // Control register fields
    // ==========================================================
    localparam int DBT_CTRL_RUN0 = 0;
    localparam int DBT_CTRL_RUN1 = 1;
    localparam int DBT_CTRL_EVCOUNT = 2;
    localparam int DBT_CTRL_EDGE_POL = 3;
    localparam int DBT_CTRL_NOISE_FLT = 4;
    localparam int DBT_CTRL_SRC0 = 5;
    localparam int DBT_CTRL_SRC1 = 6;
    localparam int DBT_CTRL_DIV0 = 7;
    localparam int DBT_CTRL_DIV1 = 9;
    localparam int DBT_CTRL_PULSE_OUT_CHANNEL_SELECT = 11;
    localparam int DBT_CTRL_POUT_EN = 12;
    localparam int DBT_CTRL_IRQ_EN0 = 13;
    localparam int DBT_CTRL_IRQ_EN1 = 14;
    localparam int DBT_CTRL_CHAIN = 15;
    localparam logic [15:0] DBT_CTRL_RST = 16'h0000;

    // Prescaler terminal counts for ratios 1, 4, 32, 256
    localparam logic [7:0] DBT_DIV_TC_1 = 8'h00;
    localparam logic [7:0] DBT_DIV_TC_4 = 8'h03;
    localparam logic [7:0] DBT_DIV_TC_32 = 8'h1f;
    localparam logic [7:0] DBT_DIV_TC_256 = 8'hff;

    // Noise rejector accepts on this many reference falling edges
    localparam logic [1:0] DBT_FLT_EDGES = 2'h2;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } dbt_wb_req_t;

    typedef struct packed {
        logic [2:0] low_speed_osc_clock_s;
        logic [2:0] high_speed_osc_clock_s;
        logic [2:0] evt_s;
        logic [2:0] ref_s;
        logic evt_flt;
        logic [1:0] flt_cnt;
        logic [15:0] ctrl;
        logic [1:0][7:0] reload;
        logic [1:0][7:0] count;
        logic [1:0][7:0] presc;
        logic [1:0][3:0] hold_hi;
        logic [1:0] irq_flag;
        logic underflow_pulse_signal;
        logic ser_clk;
        logic pin;
        logic [1:0] irq_out;
        logic ack;
        logic [31:0] rdat;
    } dbt_state_t;

    localparam dbt_state_t DBT_STATE_RST = '{
        low_speed_osc_clock_s: 3'h0, high_speed_osc_clock_s: 3'h0, evt_s: 3'h0, ref_s: 3'h0,
        evt_flt: 1'b0, flt_cnt: 2'h0, ctrl: DBT_CTRL_RST,
        reload: 16'h0000, count: 16'h0000, presc: 16'h0000,
        hold_hi: 8'h00, irq_flag: 2'h0, underflow_pulse_signal: 1'b0, ser_clk: 1'b0,
        pin: 1'b1, irq_out: 2'h0, ack: 1'b0, rdat: 32'h0000_0000
    };

endpackage

/* File: rtl/dbt_timer.sv */
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps

module dbt_timer
    import dbt_pkg::*;
#(
    // Timer count and counter width
    parameter int NUM_TIMERS = 2,
    parameter int COUNT_WIDTH = 8
)
(
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESETN,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [31:0] I_WB_DAT,
    output logic O_WB_ACK,
    output logic [31:0] O_WB_DAT,
    // Asynchronous clock and pin inputs
    input wire logic I_LOW_SPEED_OSC_CLOCK,
    input wire logic I_HIGH_SPEED_OSC_CLOCK,
    input wire logic I_REF_2048HZ,
    input wire logic I_EVENT_INPUT_PIN,
    // Outputs
    output logic O_SHARED_OUTPUT_PIN,
    output logic O_SERIAL_CLOCK,
    output logic O_TIMER0_IRQ,
    output logic O_TIMER1_IRQ
);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [7:0] div_tc(input logic [1:0] code);
        logic [7:0] tc;
        tc = DBT_DIV_TC_1;
        case (code)
            2'h1: tc = DBT_DIV_TC_4;
            2'h2: tc = DBT_DIV_TC_32;
            2'h3: tc = DBT_DIV_TC_256;
            default: tc = DBT_DIV_TC_1;
        endcase
        return tc;
    endfunction

    function automatic logic rise(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    // Write on byte lane 0 to one 8-bit register
    function automatic logic lane0_wr(input logic w,
        input dbt_wb_req_t r,
        input logic [7:0] a);
        return w & r.sel[0] & (r.adr == a);
    endfunction

    dbt_wb_req_t wb;
    dbt_state_t st_reg;
    dbt_state_t st_next;

    assign wb = '{cyc: I_WB_CYC, stb: I_WB_STB, we: I_WB_WE, sel: I_WB_SEL,
                  adr: I_WB_ADR, dat: I_WB_DAT};

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // The state struct and register map hold exactly two 8-bit timers
    if (NUM_TIMERS != 2)
    begin : g_chk_timers
        $error("dbt_timer supports exactly two timers");
    end

    if (COUNT_WIDTH != 8)
    begin : g_chk_width
        $error("dbt_timer supports only 8-bit counters");
    end

    if (DBT_FLT_EDGES == 2'h0)
    begin : g_chk_filter
        $error("noise rejector needs at least one reference edge");
    end

    if (DBT_CTRL_CHAIN > 15)
    begin : g_chk_ctrl
        $error("control fields must fit the 16-bit control register");
    end

    if (DBT_CTRL_DIV0 + 2 > DBT_CTRL_DIV1 || DBT_CTRL_DIV1 + 2 > DBT_CTRL_PULSE_OUT_CHANNEL_SELECT)
    begin : g_chk_div
        $error("divider fields overlap their neighbours");
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        logic access;
        logic wr;
        logic rd;
        logic [1:0] run;
        logic [1:0] src;
        logic [1:0][1:0] dcode;
        logic [1:0] src_edge;
        logic [1:0] tick;
        logic [1:0] uflow;
        logic [1:0] preset;
        logic evt_edge;
        logic flt_level;
        logic sel_uflow;
        logic [31:0] rd_data;
        access = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        run = 2'h0;
        src = 2'h0;
        dcode = 4'h0;
        src_edge = 2'h0;
        tick = 2'h0;
        uflow = 2'h0;
        preset = 2'h0;
        evt_edge = 1'b0;
        flt_level = 1'b0;
        sel_uflow = 1'b0;
        rd_data = 32'h0000_0000;
        st_next = st_reg;

        // Inputs from other domains: first flop feeds only the second
        st_next.low_speed_osc_clock_s = {st_reg.low_speed_osc_clock_s[1:0], I_LOW_SPEED_OSC_CLOCK};
        st_next.high_speed_osc_clock_s = {st_reg.high_speed_osc_clock_s[1:0], I_HIGH_SPEED_OSC_CLOCK};
        st_next.evt_s = {st_reg.evt_s[1:0], I_EVENT_INPUT_PIN};
        st_next.ref_s = {st_reg.ref_s[1:0], I_REF_2048HZ};

        access = wb.cyc & wb.stb & ~st_reg.ack;
        wr = access & wb.we;
        rd = access & ~wb.we;

        run[0] = st_reg.ctrl[DBT_CTRL_RUN0];
        run[1] = st_reg.ctrl[DBT_CTRL_RUN1];
        src[0] = st_reg.ctrl[DBT_CTRL_SRC0];
        src[1] = st_reg.ctrl[DBT_CTRL_SRC1];
        dcode[0] = st_reg.ctrl[DBT_CTRL_DIV0 +: 2];
        dcode[1] = st_reg.ctrl[DBT_CTRL_DIV1 +: 2];

        // Noise rejector: a change is taken at the second reference fall
        // A change that reverts before then is dropped and its count restarts
        if (!st_reg.ctrl[DBT_CTRL_NOISE_FLT])
        begin
            flt_level = st_reg.evt_s[1];
            st_next.flt_cnt = 2'h0;
        end
        else if (st_reg.evt_s[1] == st_reg.evt_flt)
        begin
            flt_level = st_reg.evt_flt;
            st_next.flt_cnt = 2'h0;
        end
        else if (st_reg.ref_s[2] & ~st_reg.ref_s[1])
        begin
            if (st_reg.flt_cnt == DBT_FLT_EDGES - 2'h1)
            begin
                flt_level = st_reg.evt_s[1];
                st_next.flt_cnt = 2'h0;
            end
            else
            begin
                flt_level = st_reg.evt_flt;
                st_next.flt_cnt = st_reg.flt_cnt + 2'h1;
            end
        end
        else
        begin
            flt_level = st_reg.evt_flt;
        end
        st_next.evt_flt = flt_level;
        evt_edge = st_reg.ctrl[DBT_CTRL_EDGE_POL] ? (flt_level & ~st_reg.evt_flt)
                                                  : (~flt_level & st_reg.evt_flt);

        // Prescalers and counters
        // A stopped prescaler keeps its phase, so a restart resumes mid-divide
        for (int t = 0; t < NUM_TIMERS; t++)
        begin
            src_edge[t] = src[t] ? rise(st_reg.high_speed_osc_clock_s) : rise(st_reg.low_speed_osc_clock_s);
            if (run[t] && src_edge[t])
            begin
                if (st_reg.presc[t] >= div_tc(dcode[t]))
                begin
                    st_next.presc[t] = 8'h00;
                    tick[t] = 1'b1;
                end
                else
                begin
                    st_next.presc[t] = st_reg.presc[t] + 8'h01;
                end
            end
        end
        // Timer 0 in event mode ignores its prescaler; timer 1 has no such mode
        if (st_reg.ctrl[DBT_CTRL_EVCOUNT])
        begin
            tick[0] = run[0] & evt_edge;
        end
        // Timer 1 keeps the prescaler tick alone

        if (lane0_wr(wr, wb, DBT_ADDR_PRESET))
        begin
            preset = wb.dat[1:0];
        end

        // Preset wins over a same-cycle tick; that tick is dropped
        for (int t = 0; t < NUM_TIMERS; t++)
        begin
            if (preset[t])
            begin
                st_next.count[t] = st_reg.reload[t];
            end
            else if (tick[t])
            begin
                if (st_reg.count[t] == 8'h00)
                begin
                    st_next.count[t] = st_reg.reload[t];
                    uflow[t] = 1'b1;
                end
                else
                begin
                    st_next.count[t] = st_reg.count[t] - 8'h01;
                end
            end
        end

        // Pulse and serial clock flip-flops
        sel_uflow = st_reg.ctrl[DBT_CTRL_PULSE_OUT_CHANNEL_SELECT] ? uflow[1] : uflow[0];
        st_next.underflow_pulse_signal = st_reg.underflow_pulse_signal ^ sel_uflow;
        st_next.ser_clk = st_reg.ser_clk ^ uflow[1];

        // ======================================================
        // Register writes
        // ======================================================
        if (wr)
        begin
            if (wb.adr == DBT_ADDR_CTRL)
            begin
                if (wb.sel[0])
                begin
                    st_next.ctrl[7:0] = wb.dat[7:0];
                end
                if (wb.sel[1])
                begin
                    st_next.ctrl[15:8] = wb.dat[15:8];
                end
            end
            else if (lane0_wr(wr, wb, DBT_ADDR_RELOAD0))
            begin
                st_next.reload[0] = wb.dat[7:0];
            end
            else if (lane0_wr(wr, wb, DBT_ADDR_RELOAD1))
            begin
                st_next.reload[1] = wb.dat[7:0];
            end
        end

        // Flags: write 1 clears, a same-cycle underflow wins
        st_next.irq_flag = st_reg.irq_flag;
        if (lane0_wr(wr, wb, DBT_ADDR_IRQ_FLAG))
        begin
            st_next.irq_flag = st_reg.irq_flag & ~wb.dat[1:0];
        end
        st_next.irq_flag = st_next.irq_flag | uflow;
        st_next.irq_out[0] = st_next.irq_flag[0] & st_next.ctrl[DBT_CTRL_IRQ_EN0];
        st_next.irq_out[1] = st_next.irq_flag[1] & st_next.ctrl[DBT_CTRL_IRQ_EN1];

        // Ungated mux: toggling the enable mid-period gives a short pulse
        st_next.pin = st_next.ctrl[DBT_CTRL_POUT_EN] ? st_next.underflow_pulse_signal : 1'b1;

        // ======================================================
        // Register reads
        // ======================================================
        // Read data stands only with ack, so an idle bus always reads zero
        if (wb.adr == DBT_ADDR_CTRL)
        begin
            rd_data = {16'h0000, st_reg.ctrl};
        end
        else if (wb.adr == DBT_ADDR_RELOAD0)
        begin
            rd_data = {24'h000000, st_reg.reload[0]};
        end
        else if (wb.adr == DBT_ADDR_RELOAD1)
        begin
            rd_data = {24'h000000, st_reg.reload[1]};
        end
        else if (wb.adr == DBT_ADDR_CNT0_LO)
        begin
            rd_data = {28'h0000000, st_reg.count[0][3:0]};
        end
        else if (wb.adr == DBT_ADDR_CNT0_HI)
        begin
            rd_data = {28'h0000000, st_reg.hold_hi[0]};
        end
        else if (wb.adr == DBT_ADDR_CNT1_LO)
        begin
            rd_data = {28'h0000000, st_reg.count[1][3:0]};
        end
        else if (wb.adr == DBT_ADDR_CNT1_HI)
        begin
            rd_data = {28'h0000000, st_reg.hold_hi[1]};
        end
        else if (wb.adr == DBT_ADDR_IRQ_FLAG)
        begin
            rd_data = {30'h00000000, st_reg.irq_flag};
        end
        else
        begin
            rd_data = 32'h0000_0000;
        end

        // Low read freezes the high nibble so a borrow cannot tear the pair
        if (rd && wb.adr == DBT_ADDR_CNT0_LO)
        begin
            st_next.hold_hi[0] = st_reg.count[0][7:4];
        end
        if (rd && wb.adr == DBT_ADDR_CNT1_LO)
        begin
            st_next.hold_hi[1] = st_reg.count[1][7:4];
        end

        st_next.ack = access;
        st_next.rdat = rd ? rd_data : 32'h0000_0000;

        if (!I_RESETN)
        begin
            st_next = DBT_STATE_RST;
        end
    end

    always_ff @(posedge I_MCLK)
    begin
        st_reg <= st_next;
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign O_WB_ACK = st_reg.ack;
    assign O_WB_DAT = st_reg.rdat;
    assign O_SHARED_OUTPUT_PIN = st_reg.pin;
    assign O_SERIAL_CLOCK = st_reg.ser_clk;
    assign O_TIMER0_IRQ = st_reg.irq_out[0];
    assign O_TIMER1_IRQ = st_reg.irq_out[1];

endmodule

/* File: tb/dbt_timer_asserts.sv */
`timescale 1ns/1ps
module dbt_timer_asserts
    import dbt_pkg::*;
(
    input logic I_MCLK,
    input logic I_RESETN,
    input logic I_WB_CYC,
    input logic I_WB_STB,
    input logic I_WB_WE,
    input logic [7:0] I_WB_ADR,
    input logic O_WB_ACK,
    input logic [31:0] O_WB_DAT,
    input logic O_SERIAL_CLOCK,
    input logic O_TIMER0_IRQ,
    input logic O_TIMER1_IRQ
);
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (!I_RESETN);
    // ==========
    // Register bus
    a_ack_follows_req: assert property (
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("ack missing");
    a_ack_one_cycle: assert property (
        O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
    a_ack_has_cause: assert property (
        $rose(O_WB_ACK) |-> $past(I_WB_CYC) && $past(I_WB_STB)) else $error("stray ack");
    a_rdat_idle_zero: assert property (
        !O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("read data without ack");
    a_unmapped_zero: assert property (
        O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) > 8'h20 |-> O_WB_DAT == 32'h0)
        else $error("unmapped read not zero");
    a_count_nibble: assert property (
        O_WB_ACK && !$past(I_WB_WE) && $past(I_WB_ADR) inside {[8'h10:8'h1c]}
        |-> O_WB_DAT[31:4] == 28'h0) else $error("count read too wide");
    // ==========
    // Underflow outputs
    // Oscillators are slower than a quarter of the system clock, so toggles are spaced
    a_serial_gap: assert property (
        $changed(O_SERIAL_CLOCK) |=> $stable(O_SERIAL_CLOCK)[*3]) else $error("serial fast");
    a_irq1_cause: assert property (
        $rose(O_TIMER1_IRQ) |-> $changed(O_SERIAL_CLOCK) || O_WB_ACK || $past(O_WB_ACK))
        else $error("irq1 rose without cause");
    a_irq_fall_cause: assert property (
        $fell(O_TIMER0_IRQ) || $fell(O_TIMER1_IRQ) |-> O_WB_ACK || $past(O_WB_ACK))
        else $error("irq fell without bus write");
endmodule

bind dbt_timer dbt_timer_asserts u_chk (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .O_WB_ACK(O_WB_ACK), .O_WB_DAT(O_WB_DAT), .O_SERIAL_CLOCK(O_SERIAL_CLOCK),
    .O_TIMER0_IRQ(O_TIMER0_IRQ), .O_TIMER1_IRQ(O_TIMER1_IRQ));

/* File: tb/dbt_timer_tb.sv */
`timescale 1ns/1ps
module dbt_timer_tb
    import dbt_pkg::*;
;
    logic I_MCLK, I_RESETN, req, we, ack, lo, hi, rf, ev, pin, ser, irq0, irq1;
    logic [7:0] adr;
    logic [31:0] wdat, odat, rdat;
    int miscompares, num_checks, ser_tg, pin_tg;

    dbt_timer dut (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_WB_CYC(req), .I_WB_STB(req),
        .I_WB_WE(we), .I_WB_SEL(4'hf), .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_ACK(ack),
        .O_WB_DAT(odat), .I_LOW_SPEED_OSC_CLOCK(lo), .I_HIGH_SPEED_OSC_CLOCK(hi),
        .I_REF_2048HZ(rf), .I_EVENT_INPUT_PIN(ev), .O_SHARED_OUTPUT_PIN(pin),
        .O_SERIAL_CLOCK(ser), .O_TIMER0_IRQ(irq0), .O_TIMER1_IRQ(irq1));

    initial
    begin
        I_MCLK = 1'b0;
        forever #50 I_MCLK = ~I_MCLK;
    end

    always @(ser) ser_tg++;
    always @(pin) pin_tg++;

    // ==========
    // Helpers
    function automatic logic [31:0] bit_at(input int i);
        return 32'h1 << i;
    endfunction

    task tick(input int n);
        repeat (n) @(posedge I_MCLK);
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_MCLK);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Waits as long as the slave needs; only the watchdog ends a hang
        do
        begin
            @(posedge I_MCLK);
        end
        while (ack !== 1'b1);
        rdat = odat;
        req <= 1'b0;
        we <= 1'b0;
        @(posedge I_MCLK);
        chk("ack_drop", 0, ack);
        // Lets registered side effects land before the caller looks at pins
        tick(1);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask

    task set_in(input int k, input logic v);
        case (k)
            0: lo <= v;
            1: hi <= v;
            2: ev <= v;
            default: rf <= v;
        endcase
    endtask

    // Long low phase covers synchroniser, filter and pin update latency
    task edges(input int k, input int n);
        repeat (n)
        begin
            set_in(k, 1'b1);
            tick(4);
            set_in(k, 1'b0);
            tick(8);
        end
    endtask

    task ev_set(input logic v);
        set_in(2, v);
        tick(8);
    endtask

    // ==========
    // Scenarios
    task t_reset;
        chk("pin", 1, pin);
        chk("serial", 0, ser);
        chk("irqs", 0, {irq1, irq0});
        rdchk(DBT_ADDR_CTRL, 0, "ctrl");
        rdchk(DBT_ADDR_RELOAD0, 0, "rld0");
    endtask

    task t_regs;
        wr(DBT_ADDR_RELOAD0, 32'hf5a);
        wr(DBT_ADDR_RELOAD1, 32'ha5);
        rdchk(DBT_ADDR_RELOAD0, 32'h5a, "rld0");
        rdchk(DBT_ADDR_RELOAD1, 32'ha5, "rld1");
        rdchk(8'h40, 0, "unmapped");
        rdchk(DBT_ADDR_PRESET, 0, "preset");
        wr(DBT_ADDR_RELOAD0, 32'h3c);
        wr(DBT_ADDR_PRESET, 1);
        rdchk(DBT_ADDR_CNT0_LO, 32'hc, "cnt_lo");
        rdchk(DBT_ADDR_CNT0_HI, 32'h3, "cnt_hi");
    endtask

    task t_presc;
        int r;
        wr(DBT_ADDR_RELOAD0, 0);
        wr(DBT_ADDR_RELOAD1, 0);
        wr(DBT_ADDR_PRESET, 3);
        for (int c = 0; c < 4; c++)
        begin
            r = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 32 : 256;
            // Timer 0 on the low oscillator, timer 1 on the high one
            wr(DBT_ADDR_CTRL, bit_at(DBT_CTRL_RUN0) | bit_at(DBT_CTRL_RUN1)
                | bit_at(DBT_CTRL_POUT_EN) | bit_at(DBT_CTRL_SRC1)
                | (c << DBT_CTRL_DIV0) | (c << DBT_CTRL_DIV1));
            ser_tg = 0;
            pin_tg = 0;
            edges(0, r);
            chk("low_osc", 0, ser_tg);
            chk("t0_div", 1, pin_tg);
            edges(1, 2 * r);
            chk("div", 2, ser_tg);
            chk("t0_src", 1, pin_tg);
        end
        wr(DBT_ADDR_CTRL, 0);
    endtask

    task t_run;
        wr(DBT_ADDR_IRQ_FLAG, 3);
        wr(DBT_ADDR_RELOAD1, 3);
        wr(DBT_ADDR_PRESET, 2);
        wr(DBT_ADDR_CTRL, bit_at(DBT_CTRL_RUN1) | bit_at(DBT_CTRL_IRQ_EN1));
        ser_tg = 0;
        edges(0, 3);
        rdchk(DBT_ADDR_CNT1_LO, 0, "cnt");
        chk("irq1", 0, irq1);
        edges(0, 1);
        chk("uflow", 1, ser_tg);
        chk("irq1", 1, irq1);
        rdchk(DBT_ADDR_CNT1_LO, 3, "reload");
        wr(DBT_ADDR_CTRL, bit_at(DBT_CTRL_RUN1));
        chk("mask", 0, irq1);
        rdchk(DBT_ADDR_IRQ_FLAG, 2, "flag");
        wr(DBT_ADDR_IRQ_FLAG, 2);
        rdchk(DBT_ADDR_IRQ_FLAG, 0, "clear");
        edges(0, 1);
        wr(DBT_ADDR_CTRL, 0);
        edges(0, 3);
        rdchk(DBT_ADDR_CNT1_LO, 2, "stop");
        wr(DBT_ADDR_CTRL, bit_at(DBT_CTRL_RUN1));
        edges(1, 2);
        edges(0, 1);
        rdchk(DBT_ADDR_CNT1_LO, 1, "resume");
    endtask

    task t_event;
        logic [31:0] base;
        base = bit_at(DBT_CTRL_RUN0) | bit_at(DBT_CTRL_EVCOUNT) | bit_at(DBT_CTRL_POUT_EN);
        base = base | bit_at(DBT_CTRL_SRC0) | (32'h3 << DBT_CTRL_DIV0);
        wr(DBT_ADDR_RELOAD0, 1);
        wr(DBT_ADDR_PRESET, 1);
        wr(DBT_ADDR_CTRL, base);
        pin_tg = 0;
        ev_set(1);
        ev_set(0);
        ev_set(1);
        chk("fall1", 0, pin_tg);
        ev_set(0);
        chk("fall2", 1, pin_tg);
        wr(DBT_ADDR_CTRL, base | bit_at(DBT_CTRL_EDGE_POL));
        pin_tg = 0;
        ev_set(1);
        ev_set(0);
        ev_set(1);
        chk("rise", 1, pin_tg);
        wr(DBT_ADDR_CTRL, base | bit_at(DBT_CTRL_EDGE_POL) | bit_at(DBT_CTRL_PULSE_OUT_CHANNEL_SELECT));
        pin_tg = 0;
        ev_set(0);
        ev_set(1);
        ev_set(0);
        ev_set(1);
        chk("pulse_out_channel_select", 0, pin_tg);
        wr(DBT_ADDR_CTRL, bit_at(DBT_CTRL_RUN0) | bit_at(DBT_CTRL_EVCOUNT));
        chk("pin_off", 1, pin);
        ev_set(0);
    endtask

    task t_filter;
        wr(DBT_ADDR_RELOAD0, 0);
        wr(DBT_ADDR_PRESET, 1);
        wr(DBT_ADDR_IRQ_FLAG, 3);
        wr(DBT_ADDR_CTRL, bit_at(DBT_CTRL_RUN0) | bit_at(DBT_CTRL_EVCOUNT)
            | bit_at(DBT_CTRL_NOISE_FLT) | bit_at(DBT_CTRL_POUT_EN)
            | bit_at(DBT_CTRL_IRQ_EN0));
        pin_tg = 0;
        ev_set(1);
        edges(3, 1);
        ev_set(0);
        edges(3, 2);
        chk("short", 0, pin_tg);
        ev_set(1);
        edges(3, 2);
        ev_set(0);
        edges(3, 1);
        chk("one_ref", 0, pin_tg);
        chk("irq0_idle", 0, irq0);
        edges(3, 1);
        chk("two_ref", 1, pin_tg);
        chk("irq0", 1, irq0);
    endtask

    // ==========
    // Run control
    task stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        {req, we, lo, hi, rf, ev} = 6'h0;
        adr = 8'h0;
        wdat = 32'h0;
        I_RESETN = 1'b0;
        repeat (20) @(posedge I_MCLK);
        I_RESETN <= 1'b1;
        tick(2);
        t_reset;
        t_regs;
        t_presc;
        t_run;
        t_event;
        t_filter;
        stop_test;
    end

    initial
    begin
        repeat (40000) @(posedge I_MCLK);
        miscompares++;
        $display("MISMATCH watchdog exp done got hang");
        stop_test;
    end
endmodule
